// >>> core/ias_pkg.sv
// Constants, register map and encodings of the image acquisition sequencer.
package ias_pkg;
    localparam int ADDR_W = 8;
    localparam int LINE_W = 20;
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_BURST = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_EXP_R = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EXP_G = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EXP_B = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATSEL = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_SEQ = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_MINLN = 8'h28;
    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FTRIG_BIT = 2;
    localparam int CTRL_ATRIG_BIT = 3;
    localparam int CTRL_DUAL_BIT = 4;
    // Command register bits, write one to issue.
    localparam int CMD_BEGIN_BIT = 0;
    localparam int CMD_FINISH_BIT = 1;
    localparam int CMD_CANCEL_BIT = 2;
    // Capture mode codes.
    localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    // Reset values.
    localparam logic [1:0] MODE_RESET = MODE_CONT;
    localparam logic [7:0] BURST_RESET = 8'h01;
    localparam logic [LINE_W-1:0] PERIOD_RESET = 20'h00000;
    localparam logic [LINE_W-1:0] EXP_RESET = 20'h00001;
    localparam logic [2:0] STATSEL_RESET = 3'h1;
    // Status flag positions, also the status view selector codes.
    localparam int ST_CAP_PEND = 0;
    localparam int ST_CAP_ALLOW = 1;
    localparam int ST_CAP_XFER = 2;
    localparam int ST_FRM_PEND = 3;
    localparam int ST_FRM_WIN = 4;
    localparam int ST_FRM_XFER = 5;
    localparam int ST_EXP_WIN = 6;
    localparam int ST_STRM_WAIT = 7;
    localparam int STATUS_SEL_BIT = 8;
    // Longest frame period and the sensor line time it is converted with.
    localparam longint MAX_PERIOD_MS = 500;
    localparam longint LINE_NS = 30000;
    localparam logic [LINE_W-1:0] MAX_PERIOD_LINES = LINE_W'(MAX_PERIOD_MS * 1000000 / LINE_NS);
    typedef enum logic [2:0] {S_IDLE, S_ARM, S_FWAIT, S_EXPOSE, S_READ, S_STREAM} ias_state_e;
endpackage

// >>> core/ias_sequencer.sv
// Acquisition sequencer: frame counting, stop/cancel handling, frame period and status flags.
//
// Contract
// - One-shot mode emits one frame per begin, then clears capture-allowed itself.
// - Burst mode emits the programmed total (1 to 255) frames, then stops.
// - Continuous mode runs at the frame period until a finish or cancel command.
// - Capture mode resets to continuous.
// - Sequence number increments on begin, clears only on finish.
// - Finish or cancel while capture is allowed clears capture-allowed and stops.
// - Ending a burst early resets the produced frame count.
// - Begin shows trigger-pending, then capture-allowed, frames, then allowed clears.
// - Frame window rises with capture-allowed, or on frame trigger if enabled.
// - One-shot mode does not run while dual exposure is selected.
// - Cancel during readout finishes readout and streaming, then clears allowed.
// - Cancel before readout lets exposure finish, drops the frame, clears allowed.
// - Cancel while waiting for a trigger clears capture-allowed at once.
// - Free-run period equals programmed lines, limited to half a second.
// - Period below the readout line count is raised to that minimum.
// - Frame period setting is ignored while frame triggering is enabled.
// - Exposure longer than the period stretches the period.
// - Status selector picks one of eight flags for reporting.
// - Exposure window spans the longest of the three colour exposures.
// - Stream wait flag follows the stream's waiting state.
// - Start trigger enabled waits for it before capture-allowed; else sets directly.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ias_sequencer (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [ias_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic acqTrigPin, // Acquisition start trigger pin
    input wire logic frameTrigPin, // Frame start trigger pin
    input wire logic lineTick, // One pulse per sensor line
    input wire logic [ias_pkg::LINE_W-1:0] minPeriodLines, // Readout lines of the area of interest
    input wire logic streamBusy, // Stream engine is sending data
    input wire logic streamDone, // Pulse: streaming of the current frame ended
    input wire logic streamWaiting, // Stream engine sits in its waiting state
    output logic captureAllowed, // Capture allowed
    output logic captureTriggerPending, // Waiting for acquisition start trigger
    output logic frameWindow, // Frame window
    output logic exposureWindow, // Exposure in progress
    output logic readoutActive, // Sensor readout in progress
    output logic streamStart, // Pulse: stream the frame just read out
    output logic statusFlag // Flag chosen by the status view selector
);
    import ias_pkg::*;

    function automatic logic [LINE_W-1:0] maxLn(input logic [LINE_W-1:0] a,
                                                input logic [LINE_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    // Register bank and APB slave state.
    logic [1:0] mode_q, mode_d;
    logic fTrigEn_q, fTrigEn_d, aTrigEn_q, aTrigEn_d, dual_q, dual_d;
    logic [7:0] burstTotal_q, burstTotal_d;
    logic [LINE_W-1:0] period_q, period_d;
    logic [LINE_W-1:0] expR_q, expR_d, expG_q, expG_d, expB_q, expB_d;
    logic [2:0] statSel_q, statSel_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic cmdBegin, cmdFinish, cmdCancel;

    // Sequencer state.
    ias_state_e state_q, state_d;
    logic [LINE_W-1:0] lineCnt_q, lineCnt_d, periodCnt_q, periodCnt_d;
    logic [7:0] framesDone_q, framesDone_d;
    logic [31:0] seqNum_q, seqNum_d;
    logic abortPend_q, abortPend_d;
    logic allowed_d, pending_d, frameWin_d, expWin_d, readout_d, streamStart_d, statusFlag_d;
    logic [7:0] flags;
    logic [LINE_W-1:0] expMax, effPeriod;

    // Pin synchronisers; the third stage only serves the edge detectors.
    logic [2:0] aSync_q, fSync_q;
    logic acqTrigRise, frameTrigRise;

    assign acqTrigRise = aSync_q[1] & ~aSync_q[2];
    assign frameTrigRise = fSync_q[1] & ~fSync_q[2];

    // APB: the access phase lasts two cycles; the write lands where pready is seen high.
    always_comb begin
        logic access;
        logic take;
        access = psel & penable;
        take = access & pready;
        mode_d = mode_q;
        fTrigEn_d = fTrigEn_q;
        aTrigEn_d = aTrigEn_q;
        dual_d = dual_q;
        burstTotal_d = burstTotal_q;
        period_d = period_q;
        expR_d = expR_q;
        expG_d = expG_q;
        expB_d = expB_q;
        statSel_d = statSel_q;
        prdata_d = prdata;
        pready_d = access & ~pready;
        pslverr_d = 1'b0;
        cmdBegin = 1'b0;
        cmdFinish = 1'b0;
        cmdCancel = 1'b0;
        if (access && !pready) begin
            prdata_d = 32'h00000000;
            unique case (paddr)
                OFF_CTRL: begin
                    prdata_d[CTRL_MODE_LSB +: 2] = mode_q;
                    prdata_d[CTRL_FTRIG_BIT] = fTrigEn_q;
                    prdata_d[CTRL_ATRIG_BIT] = aTrigEn_q;
                    prdata_d[CTRL_DUAL_BIT] = dual_q;
                end
                OFF_CMD: prdata_d = 32'h00000000;
                OFF_BURST: prdata_d[7:0] = burstTotal_q;
                OFF_PERIOD: prdata_d[LINE_W-1:0] = period_q;
                OFF_EXP_R: prdata_d[LINE_W-1:0] = expR_q;
                OFF_EXP_G: prdata_d[LINE_W-1:0] = expG_q;
                OFF_EXP_B: prdata_d[LINE_W-1:0] = expB_q;
                OFF_STATSEL: prdata_d[2:0] = statSel_q;
                OFF_STATUS: begin
                    prdata_d[7:0] = flags;
                    prdata_d[STATUS_SEL_BIT] = statusFlag;
                end
                OFF_SEQ: prdata_d = seqNum_q;
                OFF_MINLN: prdata_d[LINE_W-1:0] = minPeriodLines;
                default: pslverr_d = 1'b1;
            endcase
        end
        if (take) begin
            pslverr_d = 1'b0;
        end
        if (take && pwrite && !pslverr) begin
            unique case (paddr)
                OFF_CTRL: begin
                    mode_d = pwdata[CTRL_MODE_LSB +: 2];
                    fTrigEn_d = pwdata[CTRL_FTRIG_BIT];
                    aTrigEn_d = pwdata[CTRL_ATRIG_BIT];
                    dual_d = pwdata[CTRL_DUAL_BIT];
                end
                OFF_CMD: begin
                    cmdBegin = pwdata[CMD_BEGIN_BIT];
                    cmdFinish = pwdata[CMD_FINISH_BIT];
                    cmdCancel = pwdata[CMD_CANCEL_BIT];
                end
                OFF_BURST: begin
                    // A total of zero is outside the legal range and is dropped.
                    if (pwdata[7:0] != 8'h00) begin
                        burstTotal_d = pwdata[7:0];
                    end
                end
                OFF_PERIOD: period_d = pwdata[LINE_W-1:0];
                OFF_EXP_R: expR_d = pwdata[LINE_W-1:0];
                OFF_EXP_G: expG_d = pwdata[LINE_W-1:0];
                OFF_EXP_B: expB_d = pwdata[LINE_W-1:0];
                OFF_STATSEL: statSel_d = pwdata[2:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= MODE_RESET;
            fTrigEn_q <= 1'b0;
            aTrigEn_q <= 1'b0;
            dual_q <= 1'b0;
            burstTotal_q <= BURST_RESET;
            period_q <= PERIOD_RESET;
            expR_q <= EXP_RESET;
            expG_q <= EXP_RESET;
            expB_q <= EXP_RESET;
            statSel_q <= STATSEL_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            mode_q <= mode_d;
            fTrigEn_q <= fTrigEn_d;
            aTrigEn_q <= aTrigEn_d;
            dual_q <= dual_d;
            burstTotal_q <= burstTotal_d;
            period_q <= period_d;
            expR_q <= expR_d;
            expG_q <= expG_d;
            expB_q <= expB_d;
            statSel_q <= statSel_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // Exposure time is the longest colour channel, so the window covers all three.
    assign expMax = maxLn(expR_q, maxLn(expG_q, expB_q));
    // Free-run period: clamp to the half-second limit, raise to readout and exposure.
    assign effPeriod = maxLn(maxLn((period_q > MAX_PERIOD_LINES) ? MAX_PERIOD_LINES : period_q,
                                   minPeriodLines), expMax);

    always_comb begin
        flags = 8'h00;
        flags[ST_CAP_PEND] = captureTriggerPending;
        flags[ST_CAP_ALLOW] = captureAllowed;
        flags[ST_CAP_XFER] = captureAllowed & (streamBusy | (state_q == S_STREAM));
        flags[ST_FRM_PEND] = (state_q == S_FWAIT) & fTrigEn_q;
        flags[ST_FRM_WIN] = frameWindow;
        flags[ST_FRM_XFER] = (state_q == S_STREAM);
        flags[ST_EXP_WIN] = exposureWindow;
        flags[ST_STRM_WAIT] = streamWaiting;
    end

    always_comb begin
        logic stop;
        logic lastFrame;
        stop = 1'b0;
        lastFrame = 1'b0;
        state_d = state_q;
        lineCnt_d = lineCnt_q;
        periodCnt_d = periodCnt_q;
        framesDone_d = framesDone_q;
        seqNum_d = seqNum_q;
        abortPend_d = abortPend_q;
        allowed_d = captureAllowed;
        pending_d = 1'b0;
        frameWin_d = frameWindow;
        streamStart_d = 1'b0;
        statusFlag_d = flags[statSel_q];
        if (lineTick && periodCnt_q != {LINE_W{1'b1}}) begin
            periodCnt_d = periodCnt_q + 1'b1;
        end
        if (lineTick && (state_q == S_EXPOSE || state_q == S_READ)) begin
            lineCnt_d = lineCnt_q + 1'b1;
        end
        unique case (state_q)
            S_IDLE: begin
                // One-shot is refused while dual exposure is selected; idle only, so a
                // begin during a run never disturbs it.
                if (cmdBegin && !(mode_q == MODE_ONE_SHOT && dual_q)) begin
                    state_d = S_ARM;
                    pending_d = 1'b1;
                    seqNum_d = seqNum_q + 32'h00000001;
                end
            end
            S_ARM: begin
                pending_d = 1'b1;
                if (cmdFinish || cmdCancel) begin
                    stop = 1'b1;
                end else if (!aTrigEn_q || acqTrigRise) begin
                    pending_d = 1'b0;
                    allowed_d = 1'b1;
                    frameWin_d = ~fTrigEn_q;
                    periodCnt_d = effPeriod;
                    state_d = S_FWAIT;
                end
            end
            S_FWAIT: begin
                if (cmdFinish || cmdCancel) begin
                    stop = 1'b1;
                end else if (fTrigEn_q ? frameTrigRise : (periodCnt_q >= effPeriod)) begin
                    frameWin_d = 1'b1;
                    periodCnt_d = '0;
                    lineCnt_d = '0;
                    state_d = S_EXPOSE;
                end
            end
            S_EXPOSE: begin
                if (cmdCancel) begin
                    abortPend_d = 1'b1;
                end
                if (cmdFinish) begin
                    stop = 1'b1;
                end else if (lineCnt_q >= expMax) begin
                    lineCnt_d = '0;
                    if (abortPend_q || cmdCancel) begin
                        stop = 1'b1;
                    end else begin
                        state_d = S_READ;
                    end
                end
            end
            S_READ: begin
                if (cmdCancel) begin
                    abortPend_d = 1'b1;
                end
                if (cmdFinish) begin
                    stop = 1'b1;
                end else if (lineCnt_q >= minPeriodLines) begin
                    streamStart_d = 1'b1;
                    state_d = S_STREAM;
                end
            end
            S_STREAM: begin
                if (cmdCancel) begin
                    abortPend_d = 1'b1;
                end
                unique case (mode_q)
                    MODE_ONE_SHOT: lastFrame = 1'b1;
                    MODE_BURST: lastFrame = (framesDone_q + 8'h01 >= burstTotal_q);
                    default: lastFrame = 1'b0;
                endcase
                if (cmdFinish) begin
                    stop = 1'b1;
                end else if (streamDone) begin
                    framesDone_d = framesDone_q + 8'h01;
                    if (lastFrame || abortPend_q || cmdCancel) begin
                        stop = 1'b1;
                    end else begin
                        frameWin_d = ~fTrigEn_q;
                        state_d = S_FWAIT;
                    end
                end
            end
        endcase
        if (stop) begin
            state_d = S_IDLE;
            allowed_d = 1'b0;
            pending_d = 1'b0;
            frameWin_d = 1'b0;
            framesDone_d = 8'h00;
            abortPend_d = 1'b0;
        end
        if (cmdFinish) begin
            seqNum_d = 32'h00000000;
        end
        expWin_d = (state_d == S_EXPOSE);
        readout_d = (state_d == S_READ);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aSync_q <= 3'h0;
            fSync_q <= 3'h0;
            state_q <= S_IDLE;
            lineCnt_q <= '0;
            periodCnt_q <= '0;
            framesDone_q <= 8'h00;
            seqNum_q <= 32'h00000000;
            abortPend_q <= 1'b0;
            captureAllowed <= 1'b0;
            captureTriggerPending <= 1'b0;
            frameWindow <= 1'b0;
            exposureWindow <= 1'b0;
            readoutActive <= 1'b0;
            streamStart <= 1'b0;
            statusFlag <= 1'b0;
        end else if (ce) begin
            aSync_q <= {aSync_q[1:0], acqTrigPin};
            fSync_q <= {fSync_q[1:0], frameTrigPin};
            state_q <= state_d;
            lineCnt_q <= lineCnt_d;
            periodCnt_q <= periodCnt_d;
            framesDone_q <= framesDone_d;
            seqNum_q <= seqNum_d;
            abortPend_q <= abortPend_d;
            captureAllowed <= allowed_d;
            captureTriggerPending <= pending_d;
            frameWindow <= frameWin_d;
            exposureWindow <= expWin_d;
            readoutActive <= readout_d;
            streamStart <= streamStart_d;
            statusFlag <= statusFlag_d;
        end
    end
endmodule

// >>> verif/ias_stream_model.sv
// Stream engine and sensor line timing that sit on the far side of the sequencer.
`timescale 1ns/1ps
module ias_stream_model (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic slow, // Long streaming time when high
    input wire logic streamStart, // Request to stream a frame
    output logic lineTick, // One pulse per sensor line
    output logic streamBusy, // Frame being sent
    output logic streamDone, // Frame fully sent
    output logic streamWaiting // Engine idle and waiting
);
    logic [1:0] divQ;
    int leftQ;
    // A line lasts four clocks so that frames stay short in simulation.
    assign lineTick = (divQ == 2'h3);
    assign streamWaiting = !streamBusy;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divQ <= 2'h0;
            leftQ <= 0;
            streamBusy <= 1'b0;
            streamDone <= 1'b0;
        end else begin
            divQ <= divQ + 2'h1;
            streamDone <= (leftQ == 1);
            if (streamStart) begin
                leftQ <= slow ? 20 : 3;
                streamBusy <= 1'b1;
            end else if (leftQ > 0) begin
                leftQ <= leftQ - 1;
                streamBusy <= (leftQ > 1);
            end
        end
    end
endmodule

// >>> verif/ias_sequencer_asserts.sv
// Concurrent checks on the acquisition sequencer's ports.
`timescale 1ns/1ps
module ias_sequencer_asserts import ias_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [ias_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic captureAllowed, // Capture allowed
    input wire logic captureTriggerPending, // Start awaited
    input wire logic frameWindow, // Frame window
    input wire logic exposureWindow, // Exposure running
    input wire logic readoutActive, // Readout running
    input wire logic streamStart // Stream request
);
    logic cmdHit;
    assign cmdHit = ce && psel && penable && pready && pwrite && paddr == OFF_CMD;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_allow_after_pend: assert property ($rose(captureAllowed) |-> $past(captureTriggerPending))
        else $error("capture allowed rose without a pending start");
    a_pend_excl_allow: assert property (captureTriggerPending |-> !captureAllowed)
        else $error("pending and allowed both high");
    a_frame_needs_allow: assert property (frameWindow |-> captureAllowed)
        else $error("frame window outside capture");
    a_exp_needs_allow: assert property (exposureWindow |-> captureAllowed)
        else $error("exposure outside capture");
    a_read_needs_allow: assert property (readoutActive |-> captureAllowed)
        else $error("readout outside capture");
    a_start_pulse: assert property (streamStart |-> captureAllowed ##1 !streamStart)
        else $error("stream start not a single pulse inside capture");
    a_finish_stops: assert property (
        cmdHit && pwdata[CMD_FINISH_BIT] |=> !captureAllowed && !frameWindow)
        else $error("finish did not stop capture");
    a_cancel_wait: assert property (
        cmdHit && pwdata[CMD_CANCEL_BIT] && captureTriggerPending
        |=> !captureTriggerPending && !captureAllowed)
        else $error("cancel while waiting did not stop at once");
endmodule
bind ias_sequencer ias_sequencer_asserts ias_sequencer_asserts_i (.ref_clk, .rst_b, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .captureAllowed, .captureTriggerPending,
    .frameWindow, .exposureWindow, .readoutActive, .streamStart);

// >>> verif/ias_sequencer_tb.sv
// Self-checking bench of the acquisition sequencer with a stream engine model.
`timescale 1ns/1ps
module ias_sequencer_tb;
    import ias_pkg::*;
    localparam logic [31:0] CMD_GO = 32'h00000001;
    localparam logic [31:0] CMD_END = 32'h00000002;
    localparam logic [31:0] CMD_ABORT = 32'h00000004;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic acqTrigPin = 1'b0;
    logic frameTrigPin = 1'b0;
    logic slow = 1'b0;
    logic [LINE_W-1:0] minPeriodLines = 20'h00002;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, lineTick, streamBusy, streamDone, streamWaiting;
    logic captureAllowed, captureTriggerPending, frameWindow, exposureWindow;
    logic readoutActive, streamStart, statusFlag;
    logic [4:0] obs;
    int errTotal = 0;
    int cmpCount = 0;
    int frames = 0;
    int expCnt = 0;
    int expSeq = 0;
    int seed = 72897;
    int sizes[$];
    int f0, e0;
    assign obs = {captureTriggerPending, exposureWindow, readoutActive, frameWindow, captureAllowed};
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    ias_sequencer ias_sequencer_i (.ref_clk, .rst_b, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .acqTrigPin, .frameTrigPin, .lineTick,
        .minPeriodLines, .streamBusy, .streamDone, .streamWaiting, .captureAllowed,
        .captureTriggerPending, .frameWindow, .exposureWindow, .readoutActive, .streamStart,
        .statusFlag);
    ias_stream_model ias_stream_model_i (.ref_clk, .rst_b, .slow, .streamStart, .lineTick,
        .streamBusy, .streamDone, .streamWaiting);
    always @(posedge ref_clk) begin
        frames <= frames + int'(streamStart === 1'b1);
        expCnt <= expCnt + int'(exposureWindow === 1'b1);
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task endSim;
        $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // The request is held until pready is seen high at a rising edge.
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'(n < 50), 1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task waitBit(input int i, input logic v);
        int n;
        n = 0;
        while (obs[i] !== v && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("waitFlag", 32'(n < 20000), 1);
    endtask
    task run(input int n);
        f0 = frames;
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        waitBit(0, 1'b1);
        waitBit(0, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk("frames", frames - f0, n);
        apb(1'b0, OFF_SEQ, 0);
        chk("seq", rdat, expSeq);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        minPeriodLines <= LINE_W'(2 + $unsigned($random(seed)) % 3);
        @(posedge ref_clk);
        apb(1'b0, OFF_CTRL, 0);
        chk("mode", rdat, 32'(MODE_CONT));
        apb(1'b0, 8'h3c, 0);
        chk("unmapped", {31'h0, rerr}, 1);
        apb(1'b1, OFF_CTRL, 32'(MODE_ONE_SHOT));
        run(1);
        repeat (100) @(posedge ref_clk);
        chk("noRestart", frames - f0, 1);
        run(1);
        apb(1'b1, OFF_CTRL, 32'(MODE_BURST));
        sizes = '{1, 2 + $unsigned($random(seed)) % 6, 255};
        foreach (sizes[k]) begin
            slow <= 1'($random(seed));
            apb(1'b1, OFF_BURST, sizes[k]);
            run(sizes[k]);
        end
        apb(1'b1, OFF_BURST, 0);
        apb(1'b0, OFF_BURST, 0);
        chk("burstZero", rdat, 255);
        apb(1'b1, OFF_BURST, 4);
        f0 = frames;
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        waitBit(2, 1'b1);
        apb(1'b1, OFF_CMD, CMD_ABORT);
        waitBit(0, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk("cancelRead", frames - f0, 1);
        run(4);
        apb(1'b1, OFF_CTRL, 32'(MODE_CONT));
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        waitBit(0, 1'b1);
        f0 = frames;
        apb(1'b1, OFF_CMD, CMD_GO);
        repeat (300) @(posedge ref_clk);
        chk("contRun", 32'(frames - f0 >= 3), 1);
        chk("statusView", {31'h0, statusFlag}, 1);
        apb(1'b0, OFF_SEQ, 0);
        chk("seqBusy", rdat, expSeq);
        apb(1'b1, OFF_CMD, CMD_END);
        chk("finish", {31'h0, captureAllowed}, 0);
        f0 = frames;
        apb(1'b0, OFF_SEQ, 0);
        expSeq = 0;
        chk("seqClear", rdat, expSeq);
        repeat (100) @(posedge ref_clk);
        chk("contStop", frames - f0, 0);
        apb(1'b1, OFF_EXP_G, 3);
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        waitBit(3, 1'b1);
        f0 = frames;
        e0 = expCnt;
        apb(1'b1, OFF_CMD, CMD_ABORT);
        waitBit(0, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk("cancelExp", frames - f0, 0);
        chk("expLong", 32'(expCnt - e0 > 5), 1);
        apb(1'b1, OFF_CTRL, 32'(MODE_CONT) | 32'h8 | 32'h4);
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        repeat (20) @(posedge ref_clk);
        chk("holdStart", {30'h0, captureTriggerPending, captureAllowed}, 2);
        acqTrigPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acqTrigPin <= 1'b0;
        waitBit(0, 1'b1);
        chk("frameWait", {31'h0, frameWindow}, 0);
        frameTrigPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        frameTrigPin <= 1'b0;
        waitBit(1, 1'b1);
        apb(1'b1, OFF_CMD, CMD_END);
        expSeq = 0;
        apb(1'b1, OFF_CMD, CMD_GO);
        expSeq++;
        apb(1'b1, OFF_CMD, CMD_ABORT);
        chk("cancelWait", {30'h0, captureTriggerPending, captureAllowed}, 0);
        apb(1'b1, OFF_CTRL, 32'(MODE_ONE_SHOT) | 32'h10);
        apb(1'b1, OFF_CMD, CMD_GO);
        repeat (20) @(posedge ref_clk);
        chk("dualOne", {30'h0, captureTriggerPending, captureAllowed}, 0);
        apb(1'b0, OFF_SEQ, 0);
        chk("dualSeq", rdat, expSeq);
        apb(1'b1, OFF_BURST, 2);
        apb(1'b1, OFF_CTRL, 32'(MODE_BURST) | 32'h10);
        run(2);
        endSim;
    end
    // The longest burst dominates the run; this limit sits well beyond it.
    initial begin
        #300000;
        chk("watchdog", 1, 0);
        endSim;
    end
endmodule
